// File: core/fepd_decoder.sv
/*
  Host-side erase parameter decoder with erase watchdog.
  Assumes the host loads the eighth, ninth and tenth parameter words after
  reading them from the flash, and reports the busy bit of each status poll.
*/
`timescale 1ns/1ps
`default_nettype none
module fepd_decoder #(
  parameter int unsigned ADDR_BITS = 32,
  parameter int unsigned MS_CYCLES = fepd_pkg::FEPD_MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [31:0] word8_i,
  input wire logic [31:0] word9_i,
  input wire logic [31:0] word10_i,
  input wire logic [7:0] chip_typ_ms_i,
  input wire logic [1:0] sel_i,
  input wire logic start_i,
  input wire logic chip_i,
  input wire logic busy_i,
  output logic valid_o,
  output logic [3:0] present_o,
  output logic [31:0] instr_o,
  output logic [31:0] size_o,
  output logic [63:0] typ_ms_o,
  output logic [fepd_pkg::FEPD_WD_W-1:0] max_ms_o,
  output logic decode_err_o,
  output logic has_4k_o,
  output logic run_o,
  output logic done_o,
  output logic timeout_o,
  output logic refused_o
);
  import fepd_pkg::*;

  typedef enum logic [1:0] {FEPD_IDLE, FEPD_RUN} fepd_state_t;

  function automatic logic [15:0] fepd_typ(input logic [6:0] f);
    logic [15:0] unit;
    unit = FEPD_UNIT0_MS;
    case (f[6:5])
      2'b00: unit = FEPD_UNIT0_MS;
      2'b01: unit = FEPD_UNIT1_MS;
      2'b10: unit = FEPD_UNIT2_MS;
      default: unit = FEPD_UNIT3_MS;
    endcase
    fepd_typ = 16'((32'(f[4:0]) + 32'd1) * 32'(unit));
  endfunction : fepd_typ

  function automatic logic [FEPD_WD_W-1:0] fepd_max(input logic [15:0] t, input logic [3:0] m);
    fepd_max = FEPD_WD_W'(32'd2 * (32'(m) + 32'd1) * 32'(t));
  endfunction : fepd_max

  wire logic [63:0] slots = {word9_i, word8_i};
  logic [3:0] next_present;
  logic [31:0] next_instr;
  logic [31:0] next_size;
  logic [63:0] next_typ;
  logic next_err;
  logic next_4k;
  always_comb begin
    next_present = '0;
    next_instr = '0;
    next_size = '0;
    next_typ = '0;
    next_err = 1'b0;
    next_4k = 1'b0;
    for (int i = 0; i < FEPD_NTYPES; i++) begin
      next_size[i*8 +: 8] = slots[i*FEPD_SLOT_W + FEPD_SIZE_LSB +: 8];
      next_instr[i*8 +: 8] = slots[i*FEPD_SLOT_W + FEPD_INSTR_LSB +: 8];
      next_present[i] = next_size[i*8 +: 8] != FEPD_SIZE_NONE;
      if (next_present[i]) begin
        next_typ[i*16 +: 16] = fepd_typ(word10_i[FEPD_TIME_LSB + i*FEPD_TIME_W +: FEPD_TIME_W]);
      end
      if (next_present[i] && 32'(next_size[i*8 +: 8]) > ADDR_BITS) begin
        next_err = 1'b1;
      end
      if (next_size[i*8 +: 8] == FEPD_SIZE_4K) begin
        next_4k = 1'b1;
      end
    end
  end

  logic [3:0] mult;
  fepd_state_t state;
  logic [31:0] ms_div;
  logic [FEPD_WD_W-1:0] ms_left;
  logic busy_s1;
  logic busy_s2;
  logic busy_s3;
  logic busy_held;
  logic [1:0] settle;
  // A busy change counts only once the last two sync stages agree
  wire logic busy_ok = busy_s2 == busy_s3;
  wire logic busy_now = busy_ok ? busy_s3 : busy_held;
  wire logic settled = settle == 2'd0;
  wire logic ms_tick = ms_div == 32'(MS_CYCLES - 1);
  wire logic [15:0] sel_typ = typ_ms_o[sel_i*16 +: 16];
  wire logic [15:0] chip_typ = {8'h00, chip_typ_ms_i};
  wire logic [FEPD_WD_W-1:0] sel_max = fepd_max(chip_i ? chip_typ : sel_typ, mult);
  wire logic sel_ok = chip_i || present_o[sel_i];
  wire logic go = start_i && state == FEPD_IDLE && valid_o;

  // Decoded fields change only on a load and hold until the next one
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      present_o <= '0;
    end else if (load_i) begin
      valid_o <= 1'b1;
      present_o <= next_present;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instr_o <= '0;
      size_o <= '0;
    end else if (load_i) begin
      instr_o <= next_instr;
      size_o <= next_size;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      typ_ms_o <= '0;
      mult <= '0;
    end else if (load_i) begin
      typ_ms_o <= next_typ;
      mult <= word10_i[FEPD_MULT_LSB +: FEPD_MULT_W];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      decode_err_o <= 1'b0;
      has_4k_o <= 1'b0;
    end else if (load_i) begin
      decode_err_o <= next_err;
      has_4k_o <= next_4k;
    end
  end

  // Absent types read as zero so a caller never arms a blind watchdog
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      max_ms_o <= '0;
    end else begin
      max_ms_o <= sel_ok ? sel_max : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      busy_s3 <= 1'b0;
      busy_held <= 1'b0;
    end else begin
      busy_s1 <= busy_i;
      busy_s2 <= busy_s1;
      busy_s3 <= busy_s2;
      busy_held <= busy_now;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= FEPD_IDLE;
      ms_div <= '0;
      ms_left <= '0;
      settle <= '0;
      run_o <= 1'b0;
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      refused_o <= 1'b0;
      case (state)
        FEPD_IDLE: begin
          if (go && sel_ok && sel_max != '0) begin
            state <= FEPD_RUN;
            run_o <= 1'b1;
            ms_div <= '0;
            ms_left <= sel_max;
            settle <= FEPD_SETTLE;
          end else if (start_i) begin
            refused_o <= 1'b1;
          end
        end
        FEPD_RUN: begin
          ms_div <= ms_tick ? '0 : ms_div + 32'd1;
          // Stale sync samples from before the erase must not end it
          if (!settled) begin
            settle <= settle - 2'd1;
          end
          if (start_i) begin
            refused_o <= 1'b1;
          end
          if (settled && !busy_now) begin
            state <= FEPD_IDLE;
            run_o <= 1'b0;
            done_o <= 1'b1;
          end else if (ms_tick && ms_left == FEPD_WD_W'(1)) begin
            state <= FEPD_IDLE;
            run_o <= 1'b0;
            timeout_o <= 1'b1;
          end else if (ms_tick) begin
            ms_left <= ms_left - FEPD_WD_W'(1);
          end
        end
        default: state <= FEPD_IDLE;
      endcase
    end
  end
endmodule : fepd_decoder
`default_nettype wire

// File: core/fepd_pkg.sv
/*
  Constants for the flash erase parameter decoder: word layouts of the
  eighth, ninth and tenth parameter words and the erase time units.
  Assumes a 200 MHz host clock.
*/
// How it works
// - Word eight: type1 size/instr, type2 size/instr
// - Word nine: type3 size/instr, type4 size/instr
// - Size code N means 2^N byte granule
// - Size code zero marks erase type absent
// - Type4 time: units 31:30, count 29:25
// - Type3 time: units 24:23, count 22:18
// - Type2 time: units 17:16, count 15:11
// - Type1 time: units 10:9, count 8:4
// - Units 1/16/128/1000 ms; time=(count+1)*unit
// - Ignore time field when size is zero
// - Max time = 2*(mult+1)*typical time
// - One multiplier for all types and chip
// - Max time is the erase watchdog
// - Completion comes from polling busy
`default_nettype none
package fepd_pkg;
  localparam int unsigned FEPD_NTYPES = 4;
  localparam int unsigned FEPD_SLOT_W = 16;
  localparam int unsigned FEPD_SIZE_LSB = 0;
  localparam int unsigned FEPD_INSTR_LSB = 8;
  localparam int unsigned FEPD_TIME_LSB = 4;
  localparam int unsigned FEPD_TIME_W = 7;
  localparam int unsigned FEPD_CNT_W = 5;
  localparam int unsigned FEPD_MULT_LSB = 0;
  localparam int unsigned FEPD_MULT_W = 4;
  localparam int unsigned FEPD_MS_W = 16;
  localparam logic [15:0] FEPD_UNIT0_MS = 16'h0001;
  localparam logic [15:0] FEPD_UNIT1_MS = 16'h0010;
  localparam logic [15:0] FEPD_UNIT2_MS = 16'h0080;
  localparam logic [15:0] FEPD_UNIT3_MS = 16'h03e8;
  localparam int unsigned FEPD_CLK_MHZ = 200;
  localparam int unsigned FEPD_MS_NS = 1000000;
  localparam int unsigned FEPD_CLK_NS = 5;
  localparam int unsigned FEPD_MS_CYCLES = FEPD_MS_NS / FEPD_CLK_NS;
  localparam logic [7:0] FEPD_SIZE_NONE = 8'h00;
  localparam logic [7:0] FEPD_SIZE_4K = 8'h0c;
  localparam int unsigned FEPD_WD_W = 24;
  localparam logic [1:0] FEPD_SETTLE = 2'd3;
endpackage : fepd_pkg
`default_nettype wire

// File: tb/fepd_decoder_asserts.sv
/* Checker for the erase parameter decoder.
   Bound to fepd_decoder; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module fepd_decoder_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic start_i,
  input wire logic chip_i,
  input wire logic [1:0] sel_i,
  input wire logic [31:0] word8_i,
  input wire logic [31:0] word9_i,
  input wire logic [7:0] chip_typ_ms_i,
  input wire logic valid_o,
  input wire logic [3:0] present_o,
  input wire logic [31:0] instr_o,
  input wire logic [31:0] size_o,
  input wire logic [63:0] typ_ms_o,
  input wire logic run_o,
  input wire logic done_o,
  input wire logic timeout_o,
  input wire logic refused_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_chip_go;
    start_i && chip_i && !run_o && valid_o && chip_typ_ms_i != 8'h00;
  endsequence
  word_eight_a: assert property (load_i |=>
    {instr_o[15:8], size_o[15:8], instr_o[7:0], size_o[7:0]} == $past(word8_i)) else $error("word8 slots");
  word_nine_a: assert property (load_i |=>
    {instr_o[31:24], size_o[31:24], instr_o[23:16], size_o[23:16]} == $past(word9_i)) else $error("word9 slots");
  absent_flag_a: assert property (load_i |=> present_o[3] == ($past(word9_i[23:16]) != 8'h00))
    else $error("present bit");
  ignore_time_a: assert property (load_i && word9_i[23:16] == 8'h00 |=> typ_ms_o[63:48] == 16'h0000)
    else $error("absent time");
  busy_refuse_a: assert property (start_i && run_o |=> refused_o) else $error("start while running");
  absent_start_a: assert property (start_i && !chip_i && !run_o && !present_o[sel_i] |=> refused_o && !run_o)
    else $error("absent start");
  chip_run_a: assert property (s_chip_go |=> run_o) else $error("chip start");
  done_poll_a: assert property (done_o |-> !run_o && $past(run_o)) else $error("done");
  timeout_run_a: assert property (timeout_o |-> $past(run_o) && !done_o) else $error("timeout");
endmodule : fepd_decoder_asserts
bind fepd_decoder fepd_decoder_asserts i_chk (.*);
`default_nettype wire

// File: tb/fepd_flash_model.sv
/* Flash model: parameter words and busy.
   Assumes start_i marks an erase command. */
`timescale 1ns/1ps
`default_nettype none
module fepd_flash_model (
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic alt_i,
  input wire logic [7:0] dur_i,
  output logic [31:0] word8_o,
  output logic [31:0] word9_o,
  output logic [31:0] word10_o,
  output logic busy_o
);
  logic [7:0] left = 8'h00;
  assign word8_o = 32'h520f_200c;
  assign word9_o = alt_i ? 32'h2121_d810 : 32'hff00_d810;
  assign word10_o = 32'hff05_1001;
  assign busy_o = left != 8'h00;
  always @(posedge clock_i) left <= start_i ? dur_i : left - {7'h00, busy_o};
endmodule : fepd_flash_model
`default_nettype wire

// File: tb/test_flash_erase_param_decoder.sv
/* Testbench for the erase parameter decoder.
   Assumes the flash model supplies words and busy. */
`timescale 1ns/1ps
`default_nettype none
module test_flash_erase_param_decoder;
  import fepd_pkg::*;
  logic clock_i = 0, rst_i = 1, load_i = 0, start_i = 0, chip_i = 0, alt = 0, busy_i, valid_o, decode_err_o;
  logic has_4k_o, run_o, done_o, timeout_o, refused_o;
  logic [1:0] sel_i = 0;
  logic [7:0] dur = 0;
  logic [3:0] present_o;
  logic [31:0] word8_i, word9_i, word10_i, instr_o, size_o;
  logic [63:0] typ_ms_o;
  logic [FEPD_WD_W-1:0] max_ms_o;
  wire [2:0] evs = {refused_o, timeout_o, done_o};
  int bad_count = 0, compares = 0;
  int exp_max [5] = '{4, 192, 1024, 0, 20};
  always #2.5 clock_i = ~clock_i;
  fepd_flash_model i_flash (.clock_i, .start_i, .alt_i(alt), .dur_i(dur), .word8_o(word8_i),
    .word9_o(word9_i), .word10_o(word10_i), .busy_o(busy_i));
  fepd_decoder #(.MS_CYCLES(10)) i_dut (.*, .chip_typ_ms_i(8'h05));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task ev(input int k, input int lim);
    int n;
    n = 0;
    while (n < lim && evs[k] !== 1'b1) begin
      @(posedge clock_i);
      #1 n++;
    end
    chk(n < lim, 1);
  endtask : ev
  task go(input logic c, input logic [1:0] s, input logic [7:0] d);
    @(posedge clock_i);
    start_i <= 1;
    chip_i <= c;
    sel_i <= s;
    dur <= d;
    @(posedge clock_i);
    start_i <= 0;
    #1;
  endtask : go
  task load;
    @(posedge clock_i);
    load_i <= 1;
    @(posedge clock_i);
    load_i <= 0;
    #1;
  endtask : load
  task finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clock_i);
    rst_i <= 0;
    #1 chk({valid_o, run_o}, 0);
    load();
    chk({present_o, has_4k_o, decode_err_o}, 6'b011110);
    chk({instr_o[23:0], size_o}, 56'hd85220_00100f0c);
    chk(typ_ms_o, 64'h0000_0100_0030_0001);
    for (int s = 0; s < 5; s++) begin
      @(posedge clock_i);
      sel_i <= s[1:0];
      chip_i <= s == 4;
      repeat (2) @(posedge clock_i);
      #1 chk(max_ms_o, exp_max[s]);
    end
    $display("decode test done");
    go(0, 0, 8'h06);
    ev(0, 20);
    go(0, 0, 8'hc8);
    go(0, 0, 8'hc8);
    ev(2, 1);
    ev(1, 60);
    go(0, 3, 8'h00);
    ev(2, 1);
    go(1, 0, 8'h05);
    ev(0, 20);
    $display("watchdog test done");
    alt <= 1;
    load();
    chk(decode_err_o, 1);
    chk({valid_o, typ_ms_o[63:48]}, 17'h1_7d00);
    $display("decode error test done");
    finish_test();
  end
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule : test_flash_erase_param_decoder
`default_nettype wire
